// ---- dacvb_pkg.sv ----
// ---------------------------------------------------------------------------
// dacvb_pkg: constants for the digital audio converter verb registers
// ---------------------------------------------------------------------------
// holds node ids, verb codes, parameter ids, field positions and reset values
// assumes no surroundings; used by dacvb_regs and dacvb_regs_tb
package dacvb_pkg;

  // node ids of the two converters
  localparam logic [7:0]  NODE_OUT       = 8'h1f;
  localparam logic [7:0]  NODE_IN        = 8'h20;

  // twelve-bit verbs
  localparam logic [11:0] VERB_GET_PARAM = 12'hf00;
  localparam logic [11:0] VERB_GET_ASSIGN = 12'hf06;
  localparam logic [11:0] VERB_SET_ASSIGN = 12'h706;
  localparam logic [11:0] VERB_GET_DIGITAL_CONTROL = 12'hf0d;
  localparam logic [11:0] VERB_SET_DIGLO  = 12'h70d;
  localparam logic [11:0] VERB_SET_DIGHI  = 12'h70e;
  // four-bit verbs carrying sixteen payload bits
  localparam logic [3:0]  VERB_GET_FMT   = 4'ha;
  localparam logic [3:0]  VERB_SET_FMT   = 4'h2;

  // parameter ids
  localparam logic [7:0]  PARAM_WIDGET_CAP = 8'h09;
  localparam logic [7:0]  PARAM_FORMAT_CAP = 8'h0a;
  localparam logic [7:0]  PARAM_STREAM_CAP = 8'h0b;
  localparam logic [7:0]  PARAM_CONN_LEN   = 8'h0e;

  // widget capability fields
  localparam logic [3:0]  TYPE_AUDIO_OUT = 4'h0;
  localparam logic [3:0]  TYPE_AUDIO_IN  = 4'h1;
  localparam logic [3:0]  TYPE_VENDOR    = 4'hf;
  localparam logic [3:0]  WIDGET_CAPABILITY_DELAY     = 4'h4;
  localparam int          WIDGET_CAPABILITY_TYPE_LSB  = 20;
  localparam int          WIDGET_CAPABILITY_DELAY_LSB = 16;
  // digital stream, connection list, format override, stereo
  localparam logic [31:0] WIDGET_CAPABILITY_DIGITAL   = 32'h0000_0200;
  localparam logic [31:0] WIDGET_CAPABILITY_CONN_LIST = 32'h0000_0100;
  localparam logic [31:0] WIDGET_CAPABILITY_OVERRIDE  = 32'h0000_0010;
  localparam logic [31:0] WIDGET_CAPABILITY_STEREO    = 32'h0000_0001;

  // format capability: sizes 24/20/16 plus rate bits
  localparam logic [31:0] FCAP_SIZES     = 32'h000e_0000;
  localparam logic [31:0] FCAP_RATES_OUT = 32'h0000_05e0;
  localparam logic [31:0] FCAP_RATES_IN  = 32'h0000_0160;
  // stream types: compressed bit 2, float bit 1 clear, pcm bit 0
  localparam logic [31:0] SCAP_VALUE     = 32'h0000_0005;
  // short form list, one entry
  localparam logic [31:0] CONN_LEN_IN    = 32'h0000_0001;

  // sample format: reset 24 bits, two channels; bit 7 reserved
  localparam logic [15:0] FMT_RESET      = 16'h0031;
  localparam logic [15:0] FMT_WMASK      = 16'hff7f;
  localparam int          FMT_KIND_BIT   = 15;
  localparam int          FMT_BASE_BIT   = 14;
  localparam int          FMT_MULT_LSB   = 11;
  localparam int          FMT_DIV_LSB    = 8;
  localparam int          FMT_SIZE_LSB   = 4;
  localparam logic [15:0] DIGITAL_CONTROL_RESET   = 16'h0000;
  localparam logic [7:0]  ASSIGN_RESET   = 8'h00;

  // link framing
  localparam logic [5:0]  CMD_BITS       = 6'd40;
  localparam logic [5:0]  RESP_BITS      = 6'd32;
  // mclk cycles without a bit clock rise that end a cut frame
  localparam logic [5:0]  GAP_LIMIT      = 6'd32;

endpackage : dacvb_pkg

// ---- dacvb_regs.sv ----
// ---------------------------------------------------------------------------
// dacvb_regs: verb-addressed registers of digital audio out/in converters
// ---------------------------------------------------------------------------
// assumes a bit clock, frame sync and command line from the controller,
// all sampled by mclk_i (50 MHz) through two flip-flops each
// Summary of operation
// - out widget capability: output type, delay four, digital, override, stereo.
// - in widget capability: type 1h if input enabled else Fh, plus list present.
// - in connection list length: short form, one entry.
// - both format capabilities: 16, 20, 24 bit sizes only.
// - out rates: 44.1, 48, 88.2, 96, 192 kHz only.
// - in rates: 44.1, 48, 96 kHz only.
// - stream capability: pcm and compressed yes, float no.
// - out stream id bits 7:4, lowest channel 3:0, reset zero; zero is unused.
// - out digital control: eight flag bits plus seven-bit category code, reset zero.
// - digital control read F0D, written 70D/70E; every set answers zero.
// - format read verb A, written verb 2; bit 15 kind, bit 14 base.
// - rate multiple 000 x1, 001 x2, 011 x4; divisor field plus one.
// - sample size 8/16/20/24, reset 24; channels minus one, reset two.
// - out converter has the same sample format control as input.
// - in converter holds stream id and lowest channel via F06/706.
`timescale 1ns/1ps

module dacvb_regs #(
  parameter logic [3:0] CODEC_ADDR = 4'h0
) (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  // link pins
  input  wire logic        bit_clk_i,
  input  wire logic        sync_i,
  input  wire logic        sdo_i,
  output logic             sdi_o,
  output logic             sdi_oe_b_o,
  // strap for the input converter
  input  wire logic        dig_in_enable_i,
  // output converter controls
  output logic [15:0]      out_sample_format_o,
  output logic [7:0]       out_stream_channel_assign_o,
  output logic [15:0]      out_digital_control_o,
  output logic             out_stream_active_o,
  output logic [2:0]       out_rate_multiple_o,
  output logic [3:0]       out_rate_divisor_o,
  output logic [4:0]       out_sample_size_o,
  output logic [4:0]       out_channel_count_o,
  // input converter controls
  output logic [15:0]      in_sample_format_o,
  output logic [7:0]       in_stream_channel_assign_o,
  output logic             in_stream_active_o,
  output logic [2:0]       in_rate_multiple_o,
  output logic [3:0]       in_rate_divisor_o,
  output logic [4:0]       in_sample_size_o,
  output logic [4:0]       in_channel_count_o
);

  // -------------------------------------------------------------------------
  // decode functions
  // -------------------------------------------------------------------------
  // rate multiple factor, zero for reserved codes
  function automatic logic [2:0] dacvb_mult(input logic [2:0] code);
    case (code)
      3'h0:    dacvb_mult = 3'h1;
      3'h1:    dacvb_mult = 3'h2;
      3'h3:    dacvb_mult = 3'h4;
      default: dacvb_mult = 3'h0;
    endcase
  endfunction : dacvb_mult

  // bits per sample, zero for reserved codes
  function automatic logic [4:0] dacvb_size(input logic [2:0] code);
    case (code)
      3'h0:    dacvb_size = 5'h08;
      3'h1:    dacvb_size = 5'h10;
      3'h2:    dacvb_size = 5'h14;
      3'h3:    dacvb_size = 5'h18;
      default: dacvb_size = 5'h00;
    endcase
  endfunction : dacvb_size

  // -------------------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------------------
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic       bclk_prev;
  logic [5:0] gap_cnt;
  logic       frame_cut;

  // two flip-flops per pin; only stage b feeds logic
  always_ff @(posedge mclk_i) begin
    sync_a    <= {dig_in_enable_i, sdo_i, sync_i, bit_clk_i};
    sync_b    <= sync_a;
    bclk_prev <= sync_b[0];
  end

  wire logic bclk_rise = sync_b[0] & ~bclk_prev;
  wire logic frame_go  = bclk_rise & sync_b[1];
  wire logic sdo_bit   = sync_b[2];
  wire logic in_enable = sync_b[3];

  // -------------------------------------------------------------------------
  // command capture
  // -------------------------------------------------------------------------
  typedef enum {ST_IDLE, ST_SHIFT} dacvb_rx_type;
  dacvb_rx_type rx_state;
  logic [39:0]  cmd;
  logic [5:0]   cmd_cnt;
  logic         cmd_done;

  // shifts forty bits after each frame sync, msb first
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      rx_state <= ST_IDLE;
      cmd      <= 40'h00_0000_0000;
      cmd_cnt  <= 6'h00;
      cmd_done <= 1'b0;
    end else begin
      cmd_done <= 1'b0;
      case (rx_state)
        ST_IDLE: begin
          if (frame_go) begin
            rx_state <= ST_SHIFT;
            cmd_cnt  <= 6'h00;
          end
        end
        ST_SHIFT: begin
          if (bclk_rise) begin
            cmd     <= {cmd[38:0], sdo_bit};
            cmd_cnt <= cmd_cnt + 6'h01;
            if (cmd_cnt == dacvb_pkg::CMD_BITS - 6'h01) begin
              rx_state <= ST_IDLE;
              cmd_done <= 1'b1;
            end
          end else if (frame_cut) begin
            rx_state <= ST_IDLE; // partial command dropped
          end
        end
        default: rx_state <= ST_IDLE;
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // command decode
  // -------------------------------------------------------------------------
  wire logic        addr_hit = cmd[39:36] == CODEC_ADDR;
  wire logic [7:0]  nid      = cmd[35:28];
  wire logic [11:0] verb12   = cmd[19:8];
  wire logic [3:0]  verb4    = cmd[19:16];
  wire logic [7:0]  pay8     = cmd[7:0];
  wire logic [15:0] pay16    = cmd[15:0];
  wire logic        take     = cmd_done & addr_hit;
  wire logic        hit_out  = take & (nid == dacvb_pkg::NODE_OUT);
  wire logic        hit_in   = take & (nid == dacvb_pkg::NODE_IN);
  wire logic        is_param = verb12 == dacvb_pkg::VERB_GET_PARAM;
  wire logic        set_fmt  = verb4 == dacvb_pkg::VERB_SET_FMT;
  wire logic        set_asg  = verb12 == dacvb_pkg::VERB_SET_ASSIGN;
  wire logic        set_dlo  = verb12 == dacvb_pkg::VERB_SET_DIGLO;
  wire logic        set_dhi  = verb12 == dacvb_pkg::VERB_SET_DIGHI;

  // -------------------------------------------------------------------------
  // writable state
  // -------------------------------------------------------------------------
  logic [15:0] out_fmt;
  logic [15:0] in_fmt;
  logic [7:0]  out_asg;
  logic [7:0]  in_asg;
  logic [15:0] out_dig;

  // set verbs; reserved bits never stored
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      out_fmt <= dacvb_pkg::FMT_RESET;
      in_fmt  <= dacvb_pkg::FMT_RESET;
      out_asg <= dacvb_pkg::ASSIGN_RESET;
      in_asg  <= dacvb_pkg::ASSIGN_RESET;
      out_dig <= dacvb_pkg::DIGITAL_CONTROL_RESET;
    end else begin
      if (hit_out && set_fmt) out_fmt <= pay16 & dacvb_pkg::FMT_WMASK;
      if (hit_in && set_fmt)  in_fmt  <= pay16 & dacvb_pkg::FMT_WMASK;
      if (hit_out && set_asg) out_asg <= pay8;
      if (hit_in && set_asg)  in_asg  <= pay8;
      if (hit_out && set_dlo) out_dig[7:0]  <= pay8;
      if (hit_out && set_dhi) out_dig[14:8] <= pay8[6:0];
    end
  end

  // -------------------------------------------------------------------------
  // response selection
  // -------------------------------------------------------------------------
  wire logic [3:0]  in_type  = in_enable ? dacvb_pkg::TYPE_AUDIO_IN
                                         : dacvb_pkg::TYPE_VENDOR;
  wire logic [31:0] widget_capability_com = dacvb_pkg::WIDGET_CAPABILITY_DIGITAL | dacvb_pkg::WIDGET_CAPABILITY_OVERRIDE
                             | dacvb_pkg::WIDGET_CAPABILITY_STEREO
                             | (32'(dacvb_pkg::WIDGET_CAPABILITY_DELAY) << dacvb_pkg::WIDGET_CAPABILITY_DELAY_LSB);
  wire logic [31:0] widget_capability_out = widget_capability_com
                             | (32'(dacvb_pkg::TYPE_AUDIO_OUT) << dacvb_pkg::WIDGET_CAPABILITY_TYPE_LSB);
  wire logic [31:0] widget_capability_in  = widget_capability_com | dacvb_pkg::WIDGET_CAPABILITY_CONN_LIST
                             | (32'(in_type) << dacvb_pkg::WIDGET_CAPABILITY_TYPE_LSB);
  wire logic [31:0] fcap_out = dacvb_pkg::FCAP_SIZES | dacvb_pkg::FCAP_RATES_OUT;
  wire logic [31:0] fcap_in  = dacvb_pkg::FCAP_SIZES | dacvb_pkg::FCAP_RATES_IN;

  logic [31:0] next_resp;

  // get verbs; set verbs and unknown verbs answer zero
  always_comb begin
    next_resp = 32'h0000_0000;
    if (hit_out && is_param) begin
      case (pay8)
        dacvb_pkg::PARAM_WIDGET_CAP: next_resp = widget_capability_out;
        dacvb_pkg::PARAM_FORMAT_CAP: next_resp = fcap_out;
        dacvb_pkg::PARAM_STREAM_CAP: next_resp = dacvb_pkg::SCAP_VALUE;
        default:                     next_resp = 32'h0000_0000;
      endcase
    end else if (hit_in && is_param) begin
      case (pay8)
        dacvb_pkg::PARAM_WIDGET_CAP: next_resp = widget_capability_in;
        dacvb_pkg::PARAM_FORMAT_CAP: next_resp = fcap_in;
        dacvb_pkg::PARAM_STREAM_CAP: next_resp = dacvb_pkg::SCAP_VALUE;
        dacvb_pkg::PARAM_CONN_LEN:   next_resp = dacvb_pkg::CONN_LEN_IN;
        default:                     next_resp = 32'h0000_0000;
      endcase
    end else if (hit_out || hit_in) begin
      if (verb4 == dacvb_pkg::VERB_GET_FMT)
        next_resp = {16'h0000, hit_out ? out_fmt : in_fmt};
      else if (verb12 == dacvb_pkg::VERB_GET_ASSIGN)
        next_resp = {24'h00_0000, hit_out ? out_asg : in_asg};
      else if (hit_out && verb12 == dacvb_pkg::VERB_GET_DIGITAL_CONTROL)
        next_resp = {16'h0000, out_dig};
    end
  end

  // -------------------------------------------------------------------------
  // response shift-out in the next frame
  // -------------------------------------------------------------------------
  logic [31:0] resp;
  logic        resp_pend;
  logic [5:0]  tx_cnt;

  // answer held until the next sync, then 32 bits msb first
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      resp       <= 32'h0000_0000;
      resp_pend  <= 1'b0;
      tx_cnt     <= 6'h00;
      sdi_o      <= 1'b0;
      sdi_oe_b_o <= 1'b1;
    end else if (take && (hit_out || hit_in)) begin
      resp      <= next_resp;
      resp_pend <= 1'b1;
    end else if (frame_go && resp_pend) begin
      resp_pend  <= 1'b0;
      tx_cnt     <= dacvb_pkg::RESP_BITS;
      sdi_o      <= resp[31];
      resp       <= {resp[30:0], 1'b0};
      sdi_oe_b_o <= 1'b0;
    end else if (bclk_rise && tx_cnt != 6'h00) begin
      tx_cnt     <= tx_cnt - 6'h01;
      sdi_o      <= resp[31];
      resp       <= {resp[30:0], 1'b0};
      sdi_oe_b_o <= (tx_cnt == 6'h01);
    end else if (frame_cut) begin
      tx_cnt     <= 6'h00; // stalled clock: release the line
      sdi_o      <= 1'b0;
      sdi_oe_b_o <= 1'b1;
    end
  end

  // -------------------------------------------------------------------------
  // cut frame guard
  // -------------------------------------------------------------------------
  wire logic in_frame = (rx_state == ST_SHIFT) || (tx_cnt != 6'h00);

  // a bit clock that stops mid-frame would leave capture or answer open
  assign frame_cut = gap_cnt == dacvb_pkg::GAP_LIMIT;

  // mclk cycles since the last bit clock rise, held at the limit
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i || bclk_rise || !in_frame) begin
      gap_cnt <= 6'h00;
    end else if (!frame_cut) begin
      gap_cnt <= gap_cnt + 6'h01;
    end
  end

  // -------------------------------------------------------------------------
  // decoded control outputs
  // -------------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    out_sample_format_o         <= out_fmt;
    in_sample_format_o          <= in_fmt;
    out_stream_channel_assign_o <= out_asg;
    in_stream_channel_assign_o  <= in_asg;
    out_digital_control_o       <= out_dig;
    out_stream_active_o         <= out_asg[7:4] != 4'h0;
    in_stream_active_o          <= in_asg[7:4] != 4'h0;
    out_rate_multiple_o         <= dacvb_mult(out_fmt[13:11]);
    in_rate_multiple_o          <= dacvb_mult(in_fmt[13:11]);
    out_rate_divisor_o          <= {1'b0, out_fmt[10:8]} + 4'h1;
    in_rate_divisor_o           <= {1'b0, in_fmt[10:8]} + 4'h1;
    out_sample_size_o           <= dacvb_size(out_fmt[6:4]);
    in_sample_size_o            <= dacvb_size(in_fmt[6:4]);
    out_channel_count_o         <= {1'b0, out_fmt[3:0]} + 5'h01;
    in_channel_count_o          <= {1'b0, in_fmt[3:0]} + 5'h01;
  end

endmodule : dacvb_regs

// ---- dacvb_regs_assertions.sv ----
// dacvb_chk: port-level checks of the converter verb registers
// assumes bind into dacvb_regs; decoded outputs change in the same mclk as the register outputs
`timescale 1ns/1ps

module dacvb_chk (
  // clock and reset
  input wire logic        mclk_i,
  input wire logic        rst_b_i,
  // observed outputs
  input wire logic [15:0] out_sample_format_o, in_sample_format_o, out_digital_control_o,
  input wire logic [7:0]  out_stream_channel_assign_o, in_stream_channel_assign_o,
  input wire logic        out_stream_active_o, in_stream_active_o,
  input wire logic [2:0]  out_rate_multiple_o,
  input wire logic [3:0]  out_rate_divisor_o,
  input wire logic [4:0]  out_sample_size_o, in_sample_size_o, in_channel_count_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  // two-cycle stability window over the register outputs
  logic [47:0] q1, q2;
  wire  [47:0] cur  = {out_sample_format_o, in_sample_format_o,
                       out_stream_channel_assign_o, in_stream_channel_assign_o};
  wire  [47:0] same = ~((cur ^ q1) | (cur ^ q2));
  wire  [2:0]  mo   = out_sample_format_o[13:11];
  wire  [2:0]  so   = out_sample_format_o[6:4];
  wire  [2:0]  si   = in_sample_format_o[6:4];
  always_ff @(posedge mclk_i) begin
    q1 <= cur;
    q2 <= q1;
  end
  // decode checks, reserved bits and reset values
  property p_out_mult; &same[47:32] |-> out_rate_multiple_o ==
    (mo == 3'h0 ? 3'h1 : mo == 3'h1 ? 3'h2 : mo == 3'h3 ? 3'h4 : 3'h0); endproperty
  a_out_mult: assert property (p_out_mult) else $error("rate multiple wrong");
  property p_out_div; &same[47:32] |->
    out_rate_divisor_o == {1'b0, out_sample_format_o[10:8]} + 4'h1; endproperty
  a_out_div: assert property (p_out_div) else $error("rate divisor wrong");
  property p_out_size; &same[47:32] |-> out_sample_size_o ==
    (so == 3'h0 ? 5'h8 : so == 3'h1 ? 5'h10 : so == 3'h2 ? 5'h14 : so == 3'h3 ? 5'h18 : 5'h0);
  endproperty
  a_out_size: assert property (p_out_size) else $error("sample size wrong");
  property p_in_size; &same[31:16] |-> in_sample_size_o ==
    (si == 3'h0 ? 5'h8 : si == 3'h1 ? 5'h10 : si == 3'h2 ? 5'h14 : si == 3'h3 ? 5'h18 : 5'h0);
  endproperty
  a_in_size: assert property (p_in_size) else $error("in sample size wrong");
  property p_in_chan; &same[31:16] |->
    in_channel_count_o == {1'b0, in_sample_format_o[3:0]} + 5'h1; endproperty
  a_in_chan: assert property (p_in_chan) else $error("channel count wrong");
  property p_out_act; &same[15:8] |->
    out_stream_active_o == (out_stream_channel_assign_o[7:4] != 4'h0); endproperty
  a_out_act: assert property (p_out_act) else $error("out stream active wrong");
  property p_in_act; &same[7:0] |->
    in_stream_active_o == (in_stream_channel_assign_o[7:4] != 4'h0); endproperty
  a_in_act: assert property (p_in_act) else $error("in stream active wrong");
  property p_rsvd; out_sample_format_o[7] == 1'b0 && in_sample_format_o[7] == 1'b0
    && out_digital_control_o[15] == 1'b0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  property p_reset; $rose(rst_b_i) |-> out_sample_format_o == 16'h0031 &&
    in_sample_format_o == 16'h0031 && out_digital_control_o == 16'h0000 &&
    out_stream_channel_assign_o == 8'h00 && in_stream_channel_assign_o == 8'h00; endproperty
  a_reset: assert property (p_reset) else $error("reset values wrong");
endmodule : dacvb_chk

bind dacvb_regs dacvb_chk i_chk (.*);

// ---- dacvb_host_model.sv ----
// dacvb_host_model: link controller sending one 40-bit command per frame
// assumes the codec answers the previous command in the next frame
`timescale 1ns/1ps

module dacvb_host_model (
  // link outputs
  output logic      bit_clk_o,
  output logic      sync_o,
  output logic      sdo_o,
  // response inputs
  input wire logic  sdi_i,
  input wire logic  sdi_oe_b_i
);
  initial begin
    bit_clk_o = 1'b0;
    sync_o    = 1'b0;
    sdo_o     = 1'b0;
  end
  // one frame: bit clock runs only here and in cut; undriven response bits read unknown
  task automatic frame(input logic [39:0] cmd, output logic [31:0] rsp);
    #13;
    for (int j = 0; j <= 42; j++) begin
      sync_o = (j == 0);
      sdo_o  = (j >= 1 && j <= 40) ? cmd[40-j] : ~sdo_o;
      #80 bit_clk_o = 1'b1;
      if (j >= 1 && j <= 32) rsp[32-j] = sdi_oe_b_i ? 1'bx : sdi_i;
      #80 bit_clk_o = 1'b0;
    end
  endtask : frame
  // cut frame: sync and the first n command bits, then the bit clock stops
  task automatic cut(input logic [39:0] cmd, input int n);
    #13;
    for (int j = 0; j <= n; j++) begin
      sync_o = (j == 0);
      sdo_o  = (j >= 1) ? cmd[40-j] : 1'b0;
      #80 bit_clk_o = 1'b1;
      #80 bit_clk_o = 1'b0;
    end
    sync_o = 1'b0;
    #3000;
  endtask : cut
endmodule : dacvb_host_model

// ---- dacvb_regs_tb.sv ----
// dacvb_regs_tb: verb sequences against the converter verb registers
// assumes dacvb_host_model as link controller and the bound checker
`timescale 1ns/1ps

module dacvb_regs_tb;
  // design pins
  logic        mclk_i, rst_b_i, dig_in_enable_i, bit_clk_i, sync_i, sdo_i, sdi_o, sdi_oe_b_o;
  logic        out_stream_active_o, in_stream_active_o;
  logic [15:0] out_sample_format_o, in_sample_format_o, out_digital_control_o;
  logic [7:0]  out_stream_channel_assign_o, in_stream_channel_assign_o;
  logic [2:0]  out_rate_multiple_o, in_rate_multiple_o;
  logic [3:0]  out_rate_divisor_o, in_rate_divisor_o;
  logic [4:0]  out_sample_size_o, in_sample_size_o, out_channel_count_o, in_channel_count_o;
  int          err_total, check_count, cycles;
  logic [31:0] rsp;
  // decoded and assignment outputs gathered for compare
  wire  [16:0] out_dec  = {out_rate_multiple_o, out_rate_divisor_o, out_sample_size_o,
                           out_channel_count_o};
  wire  [16:0] in_dec   = {in_rate_multiple_o, in_rate_divisor_o, in_sample_size_o,
                           in_channel_count_o};
  wire  [31:0] asg_seen = {out_stream_channel_assign_o, in_stream_channel_assign_o, 14'h0,
                           in_stream_active_o, out_stream_active_o};
  localparam logic [7:0] NDO = dacvb_pkg::NODE_OUT;
  localparam logic [7:0] NDI = dacvb_pkg::NODE_IN;
  // capability queries and format writes with decoded results
  logic [7:0]  cap_nd [7] = '{NDO, NDO, NDO, NDI, NDI, NDI, NDI};
  logic [7:0]  cap_pm [7] = '{8'h09, 8'h0a, 8'h0b, 8'h09, 8'h0a, 8'h0b, 8'h0e};
  logic [31:0] cap_ex [7] = '{32'h0004_0211, 32'h000e_05e0, 32'h0000_0005,
                              32'h0014_0311, 32'h000e_0160, 32'h0000_0005, 32'h0000_0001};
  logic [15:0] fw [4] = '{16'h4a12, 16'h1b2f, 16'h80ff, 16'h5000};
  logic [16:0] fd [4] = '{{3'h2, 4'h3, 5'h10, 5'h3}, {3'h4, 4'h4, 5'h14, 5'h10},
                          {3'h1, 4'h1, 5'h0, 5'h10}, {3'h0, 4'h1, 5'h8, 5'h1}};

  dacvb_regs i_dut (.*);
  dacvb_host_model i_host (.bit_clk_o(bit_clk_i), .sync_o(sync_i), .sdo_o(sdo_i),
                           .sdi_i(sdi_o), .sdi_oe_b_i(sdi_oe_b_o));

  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  // hang guard
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  // command frame, then a frame to another codec that collects the answer
  task automatic xfer(input logic [7:0] nd, input logic [19:0] vp, input logic [31:0] exp);
    logic [31:0] r;
    i_host.frame({4'h0, nd, 8'h00, vp}, r);
    i_host.frame({4'hf, 36'h0}, r);
    chk(r, exp);
  endtask : xfer
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test

  initial begin
    rst_b_i = 1'b0;
    dig_in_enable_i = 1'b1;
    repeat (3) @(posedge mclk_i);
    #2 rst_b_i = 1'b1;
    repeat (4) @(posedge mclk_i);
    xfer(NDO, 20'ha0000, 32'h0000_0031);
    xfer(NDI, 20'ha0000, 32'h0000_0031);
    xfer(NDO, 20'hf0600, 32'h0);
    xfer(NDI, 20'hf0600, 32'h0);
    xfer(NDO, 20'hf0d00, 32'h0);
    foreach (cap_nd[k]) begin
      xfer(cap_nd[k], {12'hf00, cap_pm[k]}, cap_ex[k]);
    end
    @(posedge mclk_i) #2 dig_in_enable_i = 1'b0;
    xfer(NDI, 20'hf0009, 32'h00f4_0311);
    xfer(NDI, 20'h7000a, 32'h0);
    xfer(NDI, 20'hf000a, 32'h000e_0160);
    foreach (fw[k]) begin
      xfer(NDO, {4'h2, fw[k]}, 32'h0);
      xfer(NDO, 20'ha0000, {16'h0, fw[k] & 16'hff7f});
      chk({15'h0, out_dec}, {15'h0, fd[k]});
      xfer(NDI, {4'h2, fw[k]}, 32'h0);
      xfer(NDI, 20'ha0000, {16'h0, fw[k] & 16'hff7f});
      chk({15'h0, in_dec}, {15'h0, fd[k]});
    end
    xfer(NDO, 20'h7065a, 32'h0);
    xfer(NDO, 20'hf0600, 32'h0000_005a);
    chk({31'h0, out_stream_active_o}, 32'h1);
    xfer(NDI, 20'h70631, 32'h0);
    xfer(NDI, 20'hf0600, 32'h0000_0031);
    xfer(NDO, 20'h70603, 32'h0);
    chk(asg_seen, 32'h0331_0002);
    i_host.frame({4'h3, NDO, 8'h00, 20'h706f0}, rsp);
    // a frame cut one bit short must neither write nor swallow the next sync
    i_host.cut({4'h0, NDO, 8'h00, 20'h706f0}, 39);
    xfer(NDO, 20'hf0600, 32'h0000_0003);
    xfer(NDO, 20'h70dff, 32'h0);
    xfer(NDO, 20'h70eff, 32'h0);
    xfer(NDO, 20'hf0d00, 32'h0000_7fff);
    chk({16'h0, out_digital_control_o}, 32'h0000_7fff);
    xfer(NDO, 20'h70d5a, 32'h0);
    xfer(NDO, 20'h70e80, 32'h0);
    xfer(NDO, 20'hf0d00, 32'h0000_005a);
    @(posedge mclk_i) #2 rst_b_i = 1'b0;
    repeat (3) @(posedge mclk_i);
    #2 rst_b_i = 1'b1;
    repeat (4) @(posedge mclk_i);
    xfer(NDO, 20'hf0d00, 32'h0);
    chk({out_sample_format_o, 8'h0, out_stream_channel_assign_o}, 32'h0031_0000);
    finish_test();
  end
endmodule : dacvb_regs_tb
